// ### core/wael_alert_pin.sv
// alert pin shaping: level or pulse, routed to one gpio
`timescale 1ns/100ps
module wael_alert_pin (
   input wire logic clk_sys_i,                  // system clock
   input wire logic rst_n_i,                    // async reset, active low
   input wire logic alert_i,                    // internal alert level
   input wire logic new_flag_i,                 // a contributing flag newly set
   input wire wael_pkg::wael_logic_t mode_i,    // pin behaviour
   input wire logic [3:0] sel_i,                // gpio number
   output logic [wael_pkg::NCH-1:0] pin_val_o,  // pin levels
   output logic [wael_pkg::NCH-1:0] pin_sel_o   // one-hot pin owner
);
   import wael_pkg::*;
   wael_pin_state_t state_reg;
   logic [PULSE_W-1:0] cnt_reg;
   logic level_next;
   logic level_reg;

   function automatic logic [NCH-1:0] onehot(input logic [3:0] s);
      onehot = (s < 4'h8) ? (8'h01 << s) : 8'h00;
   endfunction : onehot

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= PIN_IDLE;
         cnt_reg <= '0;
      end else begin
         case (state_reg)
            PIN_IDLE: begin
               if (new_flag_i) begin
                  state_reg <= PIN_PULSE;
                  cnt_reg <= PULSE_W'(ALERT_PULSE_CYC - 1);
               end
            end
            PIN_PULSE: begin
               if (cnt_reg == '0) begin
                  state_reg <= PIN_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            default: state_reg <= PIN_IDLE;
         endcase
      end
   end

   always_comb begin
      case (mode_i)
         ALERT_ACT_LOW: level_next = !alert_i;
         ALERT_ACT_HIGH: level_next = alert_i;
         ALERT_PULSE_LOW: level_next = !(state_reg == PIN_PULSE);
         default: level_next = (state_reg == PIN_PULSE);
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_reg <= 1'b1;
         pin_sel_o <= '0;
         pin_val_o <= '0;
      end else begin
         level_reg <= level_next;
         pin_sel_o <= onehot(sel_i);
         pin_val_o <= onehot(sel_i) & {NCH{level_next}};
      end
   end

   chk_level_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (mode_i == ALERT_ACT_LOW) |=> (level_reg == !$past(alert_i)))
      else $error("active-low level wrong");
   chk_pulse_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (mode_i == ALERT_PULSE_HIGH && state_reg == PIN_IDLE && new_flag_i)
      ##1 (mode_i == ALERT_PULSE_HIGH) |=> level_reg)
      else $error("high pulse not started");
   chk_pin_route: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (sel_i < 4'h8) |=> (pin_sel_o == (8'h01 << $past(sel_i))))
      else $error("alert routed to wrong pin");
endmodule : wael_alert_pin

// ### core/wael_chan_if.sv
// per-channel link between the flag logic and one channel monitor
`timescale 1ns/100ps
interface wael_chan_if;
   logic sample_v;
   logic [11:0] result;
   logic [11:0] thr_hi;
   logic [11:0] thr_lo;
   logic [3:0] count_cfg;
   logic region;
   logic digital;
   logic din;
   logic hit_hi;
   logic hit_lo;
   modport mon (input sample_v, result, thr_hi, thr_lo, count_cfg, region, digital, din,
                output hit_hi, hit_lo);
   modport ctl (output sample_v, result, thr_hi, thr_lo, count_cfg, region, digital, din,
                input hit_hi, hit_lo);
endinterface : wael_chan_if

// ### core/wael_chan_mon.sv
// window comparator and consecutive-sample qualifier for one channel
`timescale 1ns/100ps
module wael_chan_mon (
   input wire logic clk_sys_i, // system clock
   input wire logic rst_n_i,   // async reset, active low
   wael_chan_if.mon ch         // channel link
);
   import wael_pkg::*;
   logic above, below, inband;
   logic [1:0] qual;
   logic [1:0] hit_a;
   logic [CNT_W-1:0] cnt_reg [2];
   logic din_prev_reg;
   logic rise, fall;

   assign above = ch.result > ch.thr_hi;
   assign below = ch.result < ch.thr_lo;
   assign inband = (ch.result > ch.thr_lo) && (ch.result < ch.thr_hi);
   assign qual[0] = ch.region ? inband : above;
   assign qual[1] = ch.region ? 1'b0 : below;
   assign rise = ch.din && !din_prev_reg;
   assign fall = !ch.din && din_prev_reg;

   // n+1 consecutive qualifying samples before a hit
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         hit_a[k] = ch.sample_v && !ch.digital && qual[k] && (cnt_reg[k] >= ch.count_cfg);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg[0] <= 4'h0;
         cnt_reg[1] <= 4'h0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (ch.sample_v && !ch.digital) begin
               if (!qual[k] || hit_a[k]) begin
                  cnt_reg[k] <= 4'h0;
               end else begin
                  cnt_reg[k] <= cnt_reg[k] + 4'h1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         din_prev_reg <= 1'b0;
      end else begin
         din_prev_reg <= ch.din;
      end
   end

   // digital: rising edge in region 0, falling edge in region 1
   assign ch.hit_hi = hit_a[0] || (ch.digital && !ch.region && rise);
   assign ch.hit_lo = hit_a[1] || (ch.digital && ch.region && fall);

   chk_count_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ch.sample_v && !ch.digital && qual[0] && ch.count_cfg != 4'h0 && cnt_reg[0] == 4'h0)
      |-> !ch.hit_hi)
      else $error("high hit without enough consecutive samples");
   chk_inband_hit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ch.sample_v && !ch.digital && ch.region && ch.count_cfg == 4'h0
       && ch.result > ch.thr_lo && ch.result < ch.thr_hi) |-> ch.hit_hi)
      else $error("in-band sample did not hit");
   chk_edge_hit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ch.digital && !ch.region && !ch.din) ##1 (ch.digital && !ch.region && ch.din) |-> ch.hit_hi)
      else $error("rising edge did not set high hit");
endmodule : wael_chan_mon

// ### core/wael_pkg.sv
// constants and types of the window alert event logic
package wael_pkg;
   localparam int NCH = 8;
   localparam int RES_W = 12;
   localparam int CNT_W = 4;
   localparam int ADDR_W = 8;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CH_EN = 8'h14;
   localparam logic [7:0] IDX_CRC_FLAG = 8'h15;
   localparam logic [7:0] IDX_CRC_EN = 8'h16;
   localparam logic [7:0] IDX_PIN_CFG = 8'h17;
   localparam logic [7:0] IDX_SUMMARY = 8'h18;
   localparam logic [7:0] IDX_HI = 8'h1A;
   localparam logic [7:0] IDX_LO = 8'h1C;
   localparam logic [7:0] IDX_RGN = 8'h1E;
   // field positions
   localparam int CRC_EN_BIT = 0;
   localparam int CRC_FLAG_BIT = 0;
   localparam int PIN_SEL_LSB = 4;
   localparam int LOGIC_LSB = 0;
   // reset values
   localparam logic [7:0] RST_CH_EN = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_RGN = 8'h00;
   localparam logic RST_CRC_EN = 1'h0;
   localparam logic RST_CRC_FLAG = 1'h0;
   localparam logic [3:0] RST_PIN_SEL = 4'h0;
   localparam logic [1:0] RST_LOGIC = 2'h0;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int ALERT_PULSE_NS = 1000;
   localparam int ALERT_PULSE_CYC = (ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_W = 5;
   typedef enum logic [1:0] {
      ALERT_ACT_LOW = 2'h0,
      ALERT_ACT_HIGH = 2'h1,
      ALERT_PULSE_LOW = 2'h2,
      ALERT_PULSE_HIGH = 2'h3
   } wael_logic_t;
   typedef enum logic [1:0] {
      PIN_IDLE = 2'h1,
      PIN_PULSE = 2'h2
   } wael_pin_state_t;
endpackage : wael_pkg

// ### core/wael_top.sv
// window alert event logic: flags, apb registers, alert combine
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - Only channels whose enable bit is set may drive the internal alert with their flags.
// - The internal alert leaves on the gpio numbered by the 4-bit pin select in the upper nibble.
// - With the crc alert enable set, a set input crc error flag raises the alert, else it is ignored.
// - A crc-caused alert holds until software clears the input crc error flag.
// - The 2-bit logic field picks active-low, active-high, low pulse or high pulse per flag.
// - A read-only summary register shows one bit per channel with an event detected.
// - A summary bit clears only through its high or low flag; writing the summary does nothing.
// - A high flag sets when an analog result exceeds the high threshold or a digital input rises.
// - Writing one to a high flag bit clears it and writing zero keeps it.
// - A low flag sets when an analog result falls below the low threshold or a digital input falls.
// - Writing one to a low flag bit clears it and writing zero keeps it.
// - Region zero flags results outside the window, and a digital rising edge.
// - Region one flags results inside the window, and a digital falling edge.
// - A flag needs the event count plus one consecutive qualifying samples.
// - Threshold upper 8 bits meet result bits 11:4 and lower 4 bits meet result bits 3:0.
module wael_top (
   input wire logic clk_sys_i,                                        // system clock, 25 MHz
   input wire logic rst_n_i,                                          // async reset, active low
   input wire logic psel_i,                                           // apb select
   input wire logic penable_i,                                        // apb enable
   input wire logic pwrite_i,                                         // apb direction
   input wire logic [wael_pkg::ADDR_W-1:0] paddr_i,                   // apb byte address
   input wire logic [31:0] pwdata_i,                                  // apb write data
   output logic [31:0] prdata_o,                                      // apb read data
   output logic pready_o,                                             // apb ready
   output logic pslverr_o,                                            // apb error, unmapped
   input wire logic result_valid_i,                                   // conversion result strobe
   input wire logic [2:0] result_chan_i,                              // channel of result
   input wire logic [wael_pkg::RES_W-1:0] result_data_i,              // conversion result
   input wire logic [wael_pkg::NCH-1:0] chan_digital_i,               // channel is digital input
   input wire logic [wael_pkg::NCH-1:0][7:0] thr_hi_msb_i,            // high threshold upper part
   input wire logic [wael_pkg::NCH-1:0][3:0] thr_hi_lsb_i,            // high threshold lower part
   input wire logic [wael_pkg::NCH-1:0][7:0] thr_lo_msb_i,            // low threshold upper part
   input wire logic [wael_pkg::NCH-1:0][3:0] thr_lo_lsb_i,            // low threshold lower part
   input wire logic [wael_pkg::NCH-1:0][3:0] consecutive_sample_count_i, // event count n
   input wire logic [wael_pkg::NCH-1:0] gpio_in_i,                    // gpio pin levels
   input wire logic crc_err_set_i,                                    // input crc error pulse
   output logic alert_o,                                              // internal alert level
   output logic [wael_pkg::NCH-1:0] alert_pin_val_o,                  // alert level per gpio
   output logic [wael_pkg::NCH-1:0] alert_pin_sel_o                   // gpio owned by alert
);
   import wael_pkg::*;

   logic [NCH-1:0] alert_channel_enable_reg;
   logic [NCH-1:0] upper_event_flags_reg;
   logic [NCH-1:0] upper_event_flags_next;
   logic [NCH-1:0] lower_event_flags_reg;
   logic [NCH-1:0] lower_event_flags_next;
   logic [NCH-1:0] monitor_region_select_reg;
   logic crc_input_alert_enable_reg;
   logic input_crc_error_flag_reg;
   logic input_crc_error_flag_next;
   logic [3:0] pin_sel_reg;
   wael_logic_t alert_logic_reg;
   logic [NCH-1:0] event_summary;
   logic [NCH-1:0] set_hi, set_lo;
   logic [NCH-1:0] gpio_meta_reg, gpio_sync_reg;
   logic alert_next, alert_reg, new_flag;
   logic acc_wr, setup;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      reg_hit = (a == {idx[5:0], 2'h0});
   endfunction : reg_hit

   // gpio inputs cross into the clock domain
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gpio_meta_reg <= '0;
         gpio_sync_reg <= '0;
      end else begin
         gpio_meta_reg <= gpio_in_i;
         gpio_sync_reg <= gpio_meta_reg;
      end
   end

   generate
      for (genvar gi = 0; gi < NCH; gi++) begin : g_ch
         wael_chan_if chx ();
         assign chx.sample_v = result_valid_i && (result_chan_i == 3'(gi));
         assign chx.result = result_data_i;
         assign chx.thr_hi = {thr_hi_msb_i[gi], thr_hi_lsb_i[gi]};
         assign chx.thr_lo = {thr_lo_msb_i[gi], thr_lo_lsb_i[gi]};
         assign chx.count_cfg = consecutive_sample_count_i[gi];
         assign chx.region = monitor_region_select_reg[gi];
         assign chx.digital = chan_digital_i[gi];
         assign chx.din = gpio_sync_reg[gi];
         assign set_hi[gi] = chx.hit_hi;
         assign set_lo[gi] = chx.hit_lo;
         wael_chan_mon u_mon (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .ch(chx.mon)
         );
      end
   endgenerate

   // apb: zero-wait access phase, read data caught in setup
   assign setup = psel_i && !penable_i;
   assign acc_wr = psel_i && penable_i && pwrite_i;
   assign pready_o = penable_i;
   assign prdata_o = prdata_reg;
   assign pslverr_o = pslverr_reg;

   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      if (reg_hit(paddr_i, IDX_CH_EN)) begin
         rd_byte = alert_channel_enable_reg;
      end else if (reg_hit(paddr_i, IDX_CRC_FLAG)) begin
         rd_byte = {7'h00, input_crc_error_flag_reg};
      end else if (reg_hit(paddr_i, IDX_CRC_EN)) begin
         rd_byte = {7'h00, crc_input_alert_enable_reg};
      end else if (reg_hit(paddr_i, IDX_PIN_CFG)) begin
         rd_byte = {pin_sel_reg, 2'h0, alert_logic_reg};
      end else if (reg_hit(paddr_i, IDX_SUMMARY)) begin
         rd_byte = event_summary;
      end else if (reg_hit(paddr_i, IDX_HI)) begin
         rd_byte = upper_event_flags_reg;
      end else if (reg_hit(paddr_i, IDX_LO)) begin
         rd_byte = lower_event_flags_reg;
      end else if (reg_hit(paddr_i, IDX_RGN)) begin
         rd_byte = monitor_region_select_reg;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= pwrite_i ? 32'h0 : {24'h0, rd_byte};
         pslverr_reg <= !rd_hit;
      end
   end

   // software configuration
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alert_channel_enable_reg <= RST_CH_EN;
         monitor_region_select_reg <= RST_RGN;
         crc_input_alert_enable_reg <= RST_CRC_EN;
         pin_sel_reg <= RST_PIN_SEL;
         alert_logic_reg <= wael_logic_t'(RST_LOGIC);
      end else if (acc_wr) begin
         if (reg_hit(paddr_i, IDX_CH_EN)) begin
            alert_channel_enable_reg <= pwdata_i[NCH-1:0];
         end else if (reg_hit(paddr_i, IDX_RGN)) begin
            monitor_region_select_reg <= pwdata_i[NCH-1:0];
         end else if (reg_hit(paddr_i, IDX_CRC_EN)) begin
            crc_input_alert_enable_reg <= pwdata_i[CRC_EN_BIT];
         end else if (reg_hit(paddr_i, IDX_PIN_CFG)) begin
            pin_sel_reg <= pwdata_i[PIN_SEL_LSB +: 4];
            alert_logic_reg <= wael_logic_t'(pwdata_i[LOGIC_LSB +: 2]);
         end
      end
   end

   // sticky flags: hardware set wins over write-one clear
   always_comb begin
      upper_event_flags_next = upper_event_flags_reg;
      lower_event_flags_next = lower_event_flags_reg;
      input_crc_error_flag_next = input_crc_error_flag_reg;
      if (acc_wr && reg_hit(paddr_i, IDX_HI)) begin
         upper_event_flags_next = upper_event_flags_reg & ~pwdata_i[NCH-1:0];
      end
      if (acc_wr && reg_hit(paddr_i, IDX_LO)) begin
         lower_event_flags_next = lower_event_flags_reg & ~pwdata_i[NCH-1:0];
      end
      if (acc_wr && reg_hit(paddr_i, IDX_CRC_FLAG) && pwdata_i[CRC_FLAG_BIT]) begin
         input_crc_error_flag_next = 1'b0;
      end
      upper_event_flags_next = upper_event_flags_next | set_hi;
      lower_event_flags_next = lower_event_flags_next | set_lo;
      input_crc_error_flag_next = input_crc_error_flag_next | crc_err_set_i;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         upper_event_flags_reg <= RST_FLAGS;
         lower_event_flags_reg <= RST_FLAGS;
         input_crc_error_flag_reg <= RST_CRC_FLAG;
      end else begin
         upper_event_flags_reg <= upper_event_flags_next;
         lower_event_flags_reg <= lower_event_flags_next;
         input_crc_error_flag_reg <= input_crc_error_flag_next;
      end
   end

   // summary follows the flag pair, no storage of its own
   assign event_summary = upper_event_flags_reg | lower_event_flags_reg;

   // internal alert combine
   assign alert_next = (|(event_summary & alert_channel_enable_reg))
      || (crc_input_alert_enable_reg && input_crc_error_flag_reg);
   assign new_flag = (|(((set_hi & ~upper_event_flags_reg) | (set_lo & ~lower_event_flags_reg))
      & alert_channel_enable_reg))
      || (crc_input_alert_enable_reg && crc_err_set_i && !input_crc_error_flag_reg);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= alert_next;
      end
   end
   assign alert_o = alert_reg;

   wael_alert_pin u_pin (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .alert_i(alert_reg),
      .new_flag_i(new_flag),
      .mode_i(alert_logic_reg),
      .sel_i(pin_sel_reg),
      .pin_val_o(alert_pin_val_o),
      .pin_sel_o(alert_pin_sel_o)
   );

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_gate_disabled: assert property (
      (alert_channel_enable_reg == 8'h00 && !crc_input_alert_enable_reg) |=> !alert_reg)
      else $error("alert raised with all sources disabled");
   chk_w1c_high: assert property (
      (acc_wr && reg_hit(paddr_i, IDX_HI) && set_hi == 8'h00)
      |=> ((upper_event_flags_reg & $past(pwdata_i[7:0])) == 8'h00))
      else $error("high flag not cleared by write one");
   chk_w1c_low: assert property (
      (acc_wr && reg_hit(paddr_i, IDX_LO) && set_lo == 8'h00)
      |=> ((lower_event_flags_reg & $past(pwdata_i[7:0])) == 8'h00))
      else $error("low flag not cleared by write one");
   chk_set_wins: assert property (
      (set_lo != 8'h00) |=> ((lower_event_flags_reg & $past(set_lo)) == $past(set_lo)))
      else $error("low event lost");
   chk_summary_clear: assert property (
      ((event_summary & ~$past(event_summary)) == 8'h00 && event_summary != $past(event_summary))
      |-> $past(acc_wr && (reg_hit(paddr_i, IDX_HI) || reg_hit(paddr_i, IDX_LO))))
      else $error("summary cleared without flag write");
   chk_summary_read: assert property (
      (setup && !pwrite_i && reg_hit(paddr_i, IDX_SUMMARY))
      |=> (prdata_reg[7:0] == $past(event_summary)) && !pslverr_reg)
      else $error("summary read wrong");
   chk_crc_hold: assert property (
      (crc_input_alert_enable_reg && input_crc_error_flag_reg) |=> alert_reg)
      else $error("crc alert released while flag set");
   chk_alert_release: assert property (
      ((event_summary & alert_channel_enable_reg) == 8'h00
       && !(crc_input_alert_enable_reg && input_crc_error_flag_reg)) |=> !alert_reg)
      else $error("alert stuck after flags cleared");
endmodule : wael_top

// ### tb/tb_top.sv
// bench: flag model, apb checks, alert pin modes
`timescale 1ns/100ps
module tb_top;
   import wael_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, alert, e;
   logic rv = 1'b0;
   logic crc = 1'b0;
   logic [7:0] paddr, pval, psl;
   logic [7:0] dig = 8'h00;
   logic [7:0] gpio = 8'h00;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] rch = 3'h0;
   logic [11:0] rdat = 12'h000;
   logic [11:0] d;
   logic [NCH-1:0][3:0] cnt = '0;
   logic [NCH-1:0][3:0] hl = {NCH{4'h8}};
   logic [NCH-1:0][3:0] ll = {NCH{4'h4}};
   logic [NCH-1:0][7:0] hm = {NCH{8'hC0}};
   logic [NCH-1:0][7:0] lm = {NCH{8'h40}};
   logic [7:0] ids [8] = '{IDX_CH_EN, IDX_CRC_FLAG, IDX_CRC_EN, IDX_PIN_CFG, IDX_SUMMARY, IDX_HI, IDX_LO, IDX_RGN};
   int n_errors = 0;
   int compares = 0;
   int eh = 0;
   int el = 0;
   int unsigned seed = 64776;
   int unsigned r;
   always #20 clk_sys_i = ~clk_sys_i;
   wael_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .result_valid_i(rv), .result_chan_i(rch), .result_data_i(rdat),
      .chan_digital_i(dig), .thr_hi_msb_i(hm), .thr_hi_lsb_i(hl), .thr_lo_msb_i(lm), .thr_lo_lsb_i(ll),
      .consecutive_sample_count_i(cnt), .gpio_in_i(gpio), .crc_err_set_i(crc), .alert_o(alert),
      .alert_pin_val_o(pval), .alert_pin_sel_o(psl));
   wael_host host (.clk_sys_i(clk_sys_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] x);
      host.xfer(1'b0, {idx[5:0], 2'b00}, 32'h0, rd, e);
      chk(nm, rd, x);
   endtask : rchk
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      host.xfer(1'b1, {idx[5:0], 2'b00}, {24'h0, v}, rd, e);
   endtask : wr
   task automatic samp(input logic [2:0] c, input logic [11:0] v);
      @(posedge clk_sys_i);
      rv <= 1'b1;
      rch <= c;
      rdat <= v;
      @(posedge clk_sys_i);
      rv <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
   endtask : samp
   task automatic finish_test();
      $display("counts: %0d compares, %0d mismatches", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   initial begin
      #2000000;
      n_errors++;
      $display("watchdog expired");
      finish_test();
   end
   initial begin
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      foreach (ids[i]) rchk("reset value", ids[i], 32'h0);
      host.xfer(1'b0, 8'h7C, 32'h0, rd, e);
      chk("unmapped read", {rd[30:0], e}, 32'h1);
      chk("pin at reset", {psl, pval}, 32'h0101);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         r = xs();
         d = r[19:8];
         samp(r[2:0], d);
         if (d > 12'hC08) eh |= 1 << r[2:0];
         if (d < 12'h404) el |= 1 << r[2:0];
         rchk("high flags", IDX_HI, eh);
         rchk("low flags", IDX_LO, el);
      end
      rchk("summary", IDX_SUMMARY, eh | el);
      wr(IDX_SUMMARY, 8'hFF);
      rchk("summary kept", IDX_SUMMARY, eh | el);
      chk("alert disabled", alert, 32'h0);
      wr(IDX_HI, 8'h00);
      rchk("high kept", IDX_HI, eh);
      wr(IDX_HI, 8'hFF);
      wr(IDX_LO, 8'hFF);
      rchk("low cleared", IDX_LO, 32'h0);
      rchk("summary cleared", IDX_SUMMARY, 32'h0);
      $display("test flags done");
      wr(IDX_CH_EN, 8'h01);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_PIN_CFG, {4'h5, 2'b00, m[1:0]});
         samp(3'h0, 12'hFFF);
         chk("alert on", alert, 32'h1);
         chk("pin active", {psl, 7'h0, pval[5]}, {8'h20, 7'h0, m[0]});
         repeat (30) @(posedge clk_sys_i);
         chk("pin later", pval[5], m[1] ? !m[0] : m[0]);
         wr(IDX_HI, 8'h01);
         repeat (3) @(posedge clk_sys_i);
         chk("alert off", alert, 32'h0);
      end
      $display("test pin done");
      cnt[3] <= 4'h2;
      samp(3'h3, 12'hFFF);
      samp(3'h3, 12'hFFF);
      rchk("count short", IDX_HI, 32'h0);
      samp(3'h3, 12'hFFF);
      rchk("count met", IDX_HI, 32'h08);
      wr(IDX_RGN, 8'h02);
      samp(3'h1, 12'h800);
      samp(3'h1, 12'h100);
      rchk("inside high", IDX_HI, 32'h0A);
      rchk("inside low", IDX_LO, 32'h0);
      dig <= 8'h80;
      repeat (2) @(posedge clk_sys_i);
      gpio <= 8'h80;
      repeat (6) @(posedge clk_sys_i);
      rchk("digital rise", IDX_HI, 32'h8A);
      wr(IDX_RGN, 8'h82);
      gpio <= 8'h00;
      repeat (6) @(posedge clk_sys_i);
      rchk("digital fall", IDX_LO, 32'h80);
      $display("test region done");
      @(posedge clk_sys_i);
      crc <= 1'b1;
      @(posedge clk_sys_i);
      crc <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      chk("crc masked", alert, 32'h0);
      rchk("crc flag", IDX_CRC_FLAG, 32'h1);
      wr(IDX_CRC_EN, 8'h01);
      repeat (3) @(posedge clk_sys_i);
      chk("crc alert", alert, 32'h1);
      wr(IDX_CRC_FLAG, 8'h01);
      repeat (3) @(posedge clk_sys_i);
      chk("crc released", alert, 32'h0);
      $display("test crc done");
      finish_test();
   end
endmodule : tb_top

// ### tb/wael_host.sv
// host model: apb master that reads and clears the flag registers
`timescale 1ns/100ps
module wael_host (
   input wire logic clk_sys_i, // system clock
   output logic psel_o, // apb select
   output logic penable_o, // apb enable
   output logic pwrite_o, // apb direction
   output logic [7:0] paddr_o, // apb byte address
   output logic [31:0] pwdata_o, // apb write data
   input wire logic [31:0] prdata_i, // apb read data
   input wire logic pready_i, // apb ready
   input wire logic pslverr_i // apb error
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge clk_sys_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_sys_i);
      penable_o <= 1'b1;
      do @(posedge clk_sys_i); while (pready_i !== 1'b1);
      r = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask : xfer
endmodule : wael_host
